// [dv/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, (exp), (got)); end end
module tb_top;
    import rspmc_pkg::*;
    localparam int PERIOD = 8;
    int miscompares = 0;
    int n_tests = 0;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic stack_initialise = 1'b0, stack_soft_reset_req = 1'b0;
    logic reduced_power_request = 1'b0, reduced_power_exit_request = 1'b0;
    logic [1:0] reduced_power_code = 2'h0;
    logic tx_start = 1'b0, rx_start = 1'b0, txrx_done = 1'b0, procedures_active = 1'b0;
    logic [15:0] interval_period = 16'h0008;
    logic pending_event_in = 1'b0, pending_event_service = 1'b0, reg_access_req = 1'b0;
    logic soft_reset_done, subsys_reg_reset, power_answer_valid, link_clk_en;
    logic [1:0] soft_reset_result, power_answer_code;
    logic [3:0] power_state;
    logic fast_crystal_osc_en, slow_watch_osc_timing, rf_regulators_on, retention_on;
    logic reg_access_grant, wake_irq, event_deliver, event_dropped;

    // short oscillator waits keep the wake walk a handful of cycles
    rspmc_ctrl #(.START_CYC(2), .SETTLE_CYC(2)) i_rspmc_ctrl (
        .ref_clk(ref_clk), .rst_n(rst_n), .stack_initialise(stack_initialise),
        .stack_soft_reset_req(stack_soft_reset_req),
        .reduced_power_request(reduced_power_request),
        .reduced_power_code(reduced_power_code),
        .reduced_power_exit_request(reduced_power_exit_request),
        .tx_start(tx_start), .rx_start(rx_start), .txrx_done(txrx_done),
        .procedures_active(procedures_active), .interval_period(interval_period),
        .pending_event_in(pending_event_in), .pending_event_service(pending_event_service),
        .reg_access_req(reg_access_req), .soft_reset_done(soft_reset_done),
        .soft_reset_result(soft_reset_result), .subsys_reg_reset(subsys_reg_reset),
        .power_answer_valid(power_answer_valid), .power_answer_code(power_answer_code),
        .power_state(power_state), .link_clk_en(link_clk_en),
        .fast_crystal_osc_en(fast_crystal_osc_en),
        .slow_watch_osc_timing(slow_watch_osc_timing), .rf_regulators_on(rf_regulators_on),
        .retention_on(retention_on), .reg_access_grant(reg_access_grant),
        .wake_irq(wake_irq), .event_deliver(event_deliver), .event_dropped(event_dropped)
    );

    // 20 MHz reference
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // inputs move on the falling edge, so outputs of the last rise are settled here
    task automatic tick();
        @(negedge ref_clk);
    endtask

    task automatic pwr(input logic [1:0] code);
        reduced_power_request = 1'b1;
        reduced_power_code = code;
        tick();
        reduced_power_request = 1'b0;
    endtask

    task automatic soft_reset();
        stack_soft_reset_req = 1'b1;
        tick();
        stack_soft_reset_req = 1'b0;
    endtask

    // exit request, then walk the oscillator states back to idle when via_osc is set
    task automatic wake_up(input logic via_osc);
        int i;
        logic seen_stable;
        seen_stable = 1'b0;
        reduced_power_exit_request = 1'b1;
        tick();
        reduced_power_exit_request = 1'b0;
        if (via_osc) begin
            `CHK("state_osc_on", RSPMC_ST_OSC_ON, power_state)
            for (i = 0; i < 12 && power_state !== RSPMC_ST_IDLE; i++) begin
                tick();
                if (power_state === RSPMC_ST_OSC_STABLE) seen_stable = 1'b1;
            end
            `CHK("seen_osc_stable", 1'b1, seen_stable)
        end
        `CHK("wake_state", RSPMC_ST_IDLE, power_state)
        `CHK("wake_valid", 1'b1, power_answer_valid)
        `CHK("wake_code", SUB_ACTIVE_CODE, power_answer_code)
        tick();
        `CHK("wake_pulse", 1'b0, power_answer_valid)
    endtask

    task automatic t_reset_and_early();
        `CHK("rst_state", RSPMC_ST_IDLE, power_state)
        `CHK("rst_link", 1'b1, link_clk_en)
        `CHK("rst_osc", 1'b1, fast_crystal_osc_en)
        soft_reset();
        `CHK("early_done", 1'b1, soft_reset_done)
        `CHK("early_result", INVALID_OPERATION_ERROR, soft_reset_result)
        `CHK("early_regreset", 1'b0, subsys_reg_reset)
    endtask

    // sleep: clocks, wake interrupts, event service and drop, then soft reset
    task automatic t_sleep();
        int i;
        logic irq, drop, dlv;
        irq = 1'b0;
        drop = 1'b0;
        dlv = 1'b0;
        stack_initialise = 1'b1;
        tick();
        stack_initialise = 1'b0;
        pwr(SUB_SLEEP_CODE);
        `CHK("slp_valid", 1'b1, power_answer_valid)
        `CHK("slp_code", SUB_SLEEP_CODE, power_answer_code)
        `CHK("slp_state", RSPMC_ST_SLEEP, power_state)
        `CHK("slp_link", 1'b0, link_clk_en)
        `CHK("slp_osc", 1'b1, fast_crystal_osc_en)
        pending_event_in = 1'b1;
        tick();
        pending_event_in = 1'b0;
        // each wake interrupt brings the subsystem to idle; the host puts it back to sleep
        for (i = 0; i < 3 * PERIOD + 4 && !drop; i++) begin
            if (power_state === RSPMC_ST_IDLE) pwr(SUB_SLEEP_CODE);
            else tick();
            if (wake_irq === 1'b1) irq = 1'b1;
            if (event_deliver === 1'b1) dlv = 1'b1;
            drop = (event_dropped === 1'b1);
        end
        `CHK("slp_irq", 1'b1, irq)
        `CHK("starved_drop", 1'b1, drop)
        `CHK("no_service_no_deliver", 1'b0, dlv)
        pending_event_in = 1'b1;
        tick();
        pending_event_in = 1'b0;
        pending_event_service = 1'b1;
        tick();
        pending_event_service = 1'b0;
        for (i = 0; i < 3 && !dlv; i++) begin
            dlv = (event_deliver === 1'b1);
            if (!dlv) tick();
        end
        `CHK("serviced_deliver", 1'b1, dlv)
        // exit request straight from sleep, then soft reset out of sleep
        pwr(SUB_SLEEP_CODE);
        wake_up(1'b0);
        pwr(SUB_SLEEP_CODE);
        soft_reset();
        `CHK("srst_done", 1'b1, soft_reset_done)
        `CHK("srst_result", RESULT_OK, soft_reset_result)
        `CHK("srst_regreset", 1'b1, subsys_reg_reset)
        `CHK("srst_state", RSPMC_ST_IDLE, power_state)
        `CHK("srst_no_answer", 1'b0, power_answer_valid)
    endtask

    // transfer in progress blocks sleep and deep sleep, access stays open
    task automatic t_busy();
        tx_start = 1'b1;
        tick();
        tx_start = 1'b0;
        `CHK("tx_state", RSPMC_ST_TX, power_state)
        pwr(SUB_SLEEP_CODE);
        `CHK("tx_sleep_code", SUB_ACTIVE_CODE, power_answer_code)
        `CHK("tx_sleep_state", RSPMC_ST_TX, power_state)
        reg_access_req = 1'b1;
        tick();
        pwr(SUB_DEEP_SLEEP_CODE);
        `CHK("tx_deep_code", SUB_ACTIVE_CODE, power_answer_code)
        `CHK("tx_grant", 1'b1, reg_access_grant)
        `CHK("tx_link", 1'b1, link_clk_en)
        reg_access_req = 1'b0;
        txrx_done = 1'b1;
        tick();
        txrx_done = 1'b0;
        rx_start = 1'b1;
        tick();
        rx_start = 1'b0;
        `CHK("rx_state", RSPMC_ST_RX, power_state)
        txrx_done = 1'b1;
        tick();
        txrx_done = 1'b0;
        `CHK("idle_again", RSPMC_ST_IDLE, power_state)
        pwr(SUB_ACTIVE_CODE);
        `CHK("act_req_code", SUB_ACTIVE_CODE, power_answer_code)
        `CHK("act_req_state", RSPMC_ST_IDLE, power_state)
        tick();
    endtask

    // deep sleep from idle with access held, interrupt, and full wake walk
    task automatic t_deep();
        int i;
        logic irq;
        irq = 1'b0;
        reg_access_req = 1'b1;
        pwr(SUB_DEEP_SLEEP_CODE);
        `CHK("dp_code", SUB_DEEP_SLEEP_CODE, power_answer_code)
        `CHK("dp_state", RSPMC_ST_DEEP, power_state)
        `CHK("dp_osc", 1'b0, fast_crystal_osc_en)
        `CHK("dp_slow", 1'b1, slow_watch_osc_timing)
        `CHK("dp_rf", 1'b0, rf_regulators_on)
        `CHK("dp_ret", 1'b1, retention_on)
        for (i = 0; i < PERIOD + 4 && !irq; i++) begin
            tick();
            irq = (wake_irq === 1'b1);
            `CHK("dp_grant", 1'b0, reg_access_grant)
        end
        `CHK("dp_irq", 1'b1, irq)
        wake_up(1'b1);
        tick();
        `CHK("act_grant", 1'b1, reg_access_grant)
        reg_access_req = 1'b0;
        wake_up(1'b0);
        `CHK("exit_active_state", RSPMC_ST_IDLE, power_state)
        pwr(SUB_SLEEP_CODE);
        tick();
        pwr(SUB_DEEP_SLEEP_CODE);
        `CHK("slp_to_dp", RSPMC_ST_DEEP, power_state)
        wake_up(1'b1);
    endtask

    // hibernate needs all procedures stopped, otherwise deep sleep
    task automatic t_hib();
        procedures_active = 1'b1;
        pwr(SUB_HIBERNATE_CODE);
        `CHK("hib_busy_code", SUB_DEEP_SLEEP_CODE, power_answer_code)
        `CHK("hib_busy_state", RSPMC_ST_DEEP, power_state)
        wake_up(1'b1);
        procedures_active = 1'b0;
        pwr(SUB_HIBERNATE_CODE);
        `CHK("hib_code", SUB_HIBERNATE_CODE, power_answer_code)
        `CHK("hib_state", RSPMC_ST_HIBERNATE, power_state)
        wake_up(1'b1);
    endtask

    task automatic report_and_stop();
        $display("n_tests=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) tick();
        rst_n = 1'b1;
        tick();
        t_reset_and_early();
        t_sleep();
        t_busy();
        t_deep();
        t_hib();
        report_and_stop();
    end

    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule

// [src/rspmc_ctrl.sv]
`timescale 1ns/1ps
// How it works
// - soft reset clears registers, returns to idle
// - soft reset before stack init gives error
// - blocked state falls back to shallower state
// - no register access during deep sleep
// - idle, transmit, receive: clocks on, access
// - sleep gates the link clock, fast osc stays on
// - no sleep during transmit or receive
// - deep sleep: fast osc off, slow keeps timing
// - deep sleep: radio regulators off, retention on
// - deep sleep only from idle or sleep
// - hibernate only when fully idle
// - wake interrupt every interval while reduced
// - request sleep or deep, answer entered code
// - exit request wakes subsystem, answers active
// - exit while active changes nothing
// - events delivered only on service, may drop
// - deep wake passes oscillator on, stable
module rspmc_ctrl #(
    parameter int INTERVAL_BITS = rspmc_pkg::INTERVAL_W,
    parameter int START_CYC = rspmc_pkg::OSC_START_CYC,
    parameter int SETTLE_CYC = rspmc_pkg::OSC_SETTLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic stack_initialise,
    input wire logic stack_soft_reset_req,
    input wire logic reduced_power_request,
    input wire logic [1:0] reduced_power_code,
    input wire logic reduced_power_exit_request,
    input wire logic tx_start,
    input wire logic rx_start,
    input wire logic txrx_done,
    input wire logic procedures_active,
    input wire logic [INTERVAL_BITS-1:0] interval_period,
    input wire logic pending_event_in,
    input wire logic pending_event_service,
    input wire logic reg_access_req,
    output logic soft_reset_done,
    output logic [1:0] soft_reset_result,
    output logic subsys_reg_reset,
    output logic power_answer_valid,
    output logic [1:0] power_answer_code,
    output logic [3:0] power_state,
    output logic link_clk_en,
    output logic fast_crystal_osc_en,
    output logic slow_watch_osc_timing,
    output logic rf_regulators_on,
    output logic retention_on,
    output logic reg_access_grant,
    output logic wake_irq,
    output logic event_deliver,
    output logic event_dropped
);
    import rspmc_pkg::*;

    rspmc_state_t state, next_state;
    logic initialised;
    logic exit_pending;
    logic [7:0] wait_cnt;
    logic event_queued;
    logic [1:0] missed;

    // state classes
    wire is_active = (state == RSPMC_ST_IDLE) || (state == RSPMC_ST_TX) ||
                     (state == RSPMC_ST_RX);
    wire is_reduced = (state == RSPMC_ST_SLEEP) || (state == RSPMC_ST_DEEP) ||
                      (state == RSPMC_ST_HIBERNATE);
    wire busy_txrx = (state == RSPMC_ST_TX) || (state == RSPMC_ST_RX);
    wire soft_ok = stack_soft_reset_req && initialised;
    wire soft_bad = stack_soft_reset_req && !initialised;
    wire tick;

    // entry conditions; a refused state falls back toward the shallower one
    wire can_hib = (state == RSPMC_ST_IDLE) && !procedures_active;
    wire can_deep = (state == RSPMC_ST_IDLE) || (state == RSPMC_ST_SLEEP);
    wire can_sleep = (state == RSPMC_ST_IDLE) || (state == RSPMC_ST_SLEEP);
    wire want_hib = reduced_power_code == SUB_HIBERNATE_CODE;
    wire want_deep = want_hib || (reduced_power_code == SUB_DEEP_SLEEP_CODE);
    wire want_sleep = reduced_power_code != SUB_ACTIVE_CODE;
    wire [1:0] entered_code =
        (want_hib && can_hib) ? SUB_HIBERNATE_CODE :
        (want_deep && can_deep) ? SUB_DEEP_SLEEP_CODE :
        (want_sleep && can_sleep) ? SUB_SLEEP_CODE : SUB_ACTIVE_CODE;
    wire wait_done = wait_cnt == 8'h00;

    // answer code for the state a given target lands in
    function automatic logic [1:0] code_of(rspmc_state_t s);
        logic [1:0] c;
        c = SUB_ACTIVE_CODE;
        if (s == RSPMC_ST_SLEEP) begin
            c = SUB_SLEEP_CODE;
        end else if (s == RSPMC_ST_DEEP) begin
            c = SUB_DEEP_SLEEP_CODE;
        end else if (s == RSPMC_ST_HIBERNATE) begin
            c = SUB_HIBERNATE_CODE;
        end
        return c;
    endfunction

    // next state; soft reset dominates every other request
    always_comb begin
        next_state = state;
        if (soft_ok) begin
            next_state = RSPMC_ST_IDLE;
        end else begin
            unique case (state)
                RSPMC_ST_IDLE: begin
                    if (reduced_power_request && entered_code == SUB_HIBERNATE_CODE) begin
                        next_state = RSPMC_ST_HIBERNATE;
                    end else if (reduced_power_request && entered_code == SUB_DEEP_SLEEP_CODE) begin
                        next_state = RSPMC_ST_DEEP;
                    end else if (reduced_power_request && entered_code == SUB_SLEEP_CODE) begin
                        next_state = RSPMC_ST_SLEEP;
                    end else if (tx_start) begin
                        next_state = RSPMC_ST_TX;
                    end else if (rx_start) begin
                        next_state = RSPMC_ST_RX;
                    end
                end
                RSPMC_ST_TX, RSPMC_ST_RX: begin
                    if (txrx_done) begin
                        next_state = RSPMC_ST_IDLE;
                    end
                end
                RSPMC_ST_SLEEP: begin
                    if (reduced_power_exit_request || tick) begin
                        next_state = RSPMC_ST_IDLE;
                    end else if (reduced_power_request &&
                                 entered_code == SUB_DEEP_SLEEP_CODE) begin
                        next_state = RSPMC_ST_DEEP;
                    end
                end
                RSPMC_ST_DEEP, RSPMC_ST_HIBERNATE: begin
                    if (reduced_power_exit_request || tick) begin
                        next_state = RSPMC_ST_OSC_ON;
                    end
                end
                RSPMC_ST_OSC_ON: begin
                    if (wait_done) begin
                        next_state = RSPMC_ST_OSC_STABLE;
                    end
                end
                RSPMC_ST_OSC_STABLE: begin
                    if (wait_done) begin
                        next_state = RSPMC_ST_IDLE;
                    end
                end
                default: next_state = RSPMC_ST_IDLE;
            endcase
        end
    end

    // wake interval timer runs only while in a reduced state
    rspmc_interval_timer #(
        .W(INTERVAL_BITS)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(is_reduced),
        .period(interval_period),
        .tick(tick)
    );

    // state register and stack init flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= RSPMC_ST_IDLE;
            initialised <= 1'b0;
        end else begin
            state <= next_state;
            initialised <= initialised | stack_initialise;
        end
    end

    // oscillator start and settle wait
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wait_cnt <= 8'h00;
        end else if (next_state == RSPMC_ST_OSC_ON && state != RSPMC_ST_OSC_ON) begin
            wait_cnt <= 8'(START_CYC - 1);
        end else if (next_state == RSPMC_ST_OSC_STABLE && state != RSPMC_ST_OSC_STABLE) begin
            wait_cnt <= 8'(SETTLE_CYC - 1);
        end else if (!wait_done) begin
            wait_cnt <= wait_cnt - 8'h01;
        end
    end

    // exit request blocks until active; answered then, only once
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_ok) begin
            exit_pending <= 1'b0;
        end else if (reduced_power_exit_request && !is_active) begin
            exit_pending <= 1'b1;
        end else if (is_active) begin
            exit_pending <= 1'b0;
        end
    end

    // answers: one-cycle pulse with the code of the state entered
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            power_answer_valid <= 1'b0;
            power_answer_code <= SUB_ACTIVE_CODE;
        end else if (reduced_power_request && !reduced_power_exit_request) begin
            power_answer_valid <= 1'b1;
            power_answer_code <= is_reduced ? code_of(next_state) : entered_code;
        end else if (reduced_power_exit_request && is_active) begin
            power_answer_valid <= 1'b1;
            power_answer_code <= SUB_ACTIVE_CODE;
        end else if ((exit_pending || reduced_power_exit_request) && !is_active &&
                     next_state == RSPMC_ST_IDLE) begin
            // only on the step into idle: exit_pending lingers one cycle after it
            power_answer_valid <= 1'b1;
            power_answer_code <= SUB_ACTIVE_CODE;
        end else begin
            power_answer_valid <= 1'b0;
        end
    end

    // soft reset answer and register reset pulse; no event raised
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            soft_reset_done <= 1'b0;
            soft_reset_result <= RESULT_OK;
            subsys_reg_reset <= 1'b0;
        end else begin
            soft_reset_done <= stack_soft_reset_req;
            soft_reset_result <= soft_bad ? INVALID_OPERATION_ERROR : RESULT_OK;
            subsys_reg_reset <= soft_ok;
        end
    end

    // clock, oscillator and regulator controls follow the next state
    wire nx_active = (next_state == RSPMC_ST_IDLE) || (next_state == RSPMC_ST_TX) ||
                     (next_state == RSPMC_ST_RX);
    wire nx_osc_off = (next_state == RSPMC_ST_DEEP) || (next_state == RSPMC_ST_HIBERNATE);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            link_clk_en <= 1'b1;
            fast_crystal_osc_en <= 1'b1;
            slow_watch_osc_timing <= 1'b0;
            rf_regulators_on <= 1'b1;
            retention_on <= 1'b0;
            power_state <= RSPMC_ST_IDLE;
        end else begin
            link_clk_en <= nx_active;
            fast_crystal_osc_en <= !nx_osc_off;
            slow_watch_osc_timing <= nx_osc_off;
            rf_regulators_on <= !nx_osc_off && next_state != RSPMC_ST_OSC_ON;
            retention_on <= nx_osc_off;
            power_state <= next_state;
        end
    end

    // register access refused while retention only keeps the logic alive
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_access_grant <= 1'b0;
        end else begin
            reg_access_grant <= reg_access_req && nx_active;
        end
    end

    // wake interrupt pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wake_irq <= 1'b0;
        end else begin
            wake_irq <= tick;
        end
    end

    // events wait for service; starved ones are dropped after two intervals
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_ok) begin
            event_queued <= 1'b0;
            missed <= 2'h0;
            event_deliver <= 1'b0;
            event_dropped <= 1'b0;
        end else begin
            event_deliver <= pending_event_service && event_queued;
            event_dropped <= 1'b0;
            if (pending_event_in) begin
                event_queued <= 1'b1; // new event wins over service clear
                missed <= 2'h0;
            end else if (pending_event_service) begin
                event_queued <= 1'b0;
                missed <= 2'h0;
            end else if (tick && event_queued) begin
                if (missed == 2'h1) begin
                    event_queued <= 1'b0;
                    event_dropped <= 1'b1;
                    missed <= 2'h0;
                end else begin
                    missed <= missed + 2'h1;
                end
            end
        end
    end

    // checks
    sequence deep_wake_s;
        state == RSPMC_ST_OSC_ON ##[1:300] state == RSPMC_ST_OSC_STABLE;
    endsequence

    soft_reset_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        soft_ok |=> state == RSPMC_ST_IDLE && subsys_reg_reset)
        else $error("soft reset did not return to idle");
    soft_reset_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        soft_bad |=> soft_reset_result == INVALID_OPERATION_ERROR && !subsys_reg_reset)
        else $error("early soft reset not refused");
    no_sleep_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busy_txrx && !soft_ok |=> state != RSPMC_ST_SLEEP)
        else $error("sleep entered during transfer");
    deep_access_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == RSPMC_ST_DEEP |-> !reg_access_grant)
        else $error("access granted in deep sleep");
    deep_from_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(state == RSPMC_ST_DEEP) |-> $past(state) == RSPMC_ST_IDLE ||
        $past(state) == RSPMC_ST_SLEEP)
        else $error("deep sleep from illegal state");
    deep_osc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == RSPMC_ST_DEEP && $past(state) == RSPMC_ST_DEEP |->
        !fast_crystal_osc_en && slow_watch_osc_timing && !rf_regulators_on)
        else $error("deep sleep oscillators wrong");
    wake_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(state == RSPMC_ST_OSC_ON) && !soft_ok |-> deep_wake_s)
        else $error("deep wake sequence broken");
    state_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        power_state == 4'(state))
        else $error("state output stale");
    wake_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wake_irq |-> $past(is_reduced, 2))
        else $error("wake interrupt while active");
    sleep_clocks_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == RSPMC_ST_SLEEP |-> !link_clk_en && fast_crystal_osc_en)
        else $error("sleep clock gating wrong");
    exit_active_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reduced_power_exit_request && is_active && !reduced_power_request |=>
        power_answer_valid && power_answer_code == SUB_ACTIVE_CODE)
        else $error("exit while active not answered");
endmodule

// [src/rspmc_interval_timer.sv]
`timescale 1ns/1ps
// counts one interval and pulses at each expiry while enabled
module rspmc_interval_timer #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [W-1:0] period,
    output logic tick
);
    logic [W-1:0] count;
    wire expire = run && (count >= period - W'(1));

    // counter restarts whenever disabled so each sleep starts a full interval
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !run || expire) begin
            count <= '0;
        end else begin
            count <= count + W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= expire;
        end
    end
endmodule

// [src/rspmc_pkg.sv]
package rspmc_pkg;
    // power state codes reported to the controlling party
    typedef enum logic [3:0] {
        RSPMC_ST_IDLE = 4'b0000,
        RSPMC_ST_TX = 4'b0001,
        RSPMC_ST_RX = 4'b0010,
        RSPMC_ST_SLEEP = 4'b0011,
        RSPMC_ST_DEEP = 4'b0100,
        RSPMC_ST_OSC_ON = 4'b0101,
        RSPMC_ST_OSC_STABLE = 4'b0110,
        RSPMC_ST_HIBERNATE = 4'b0111
    } rspmc_state_t;

    // request / answer codes
    localparam logic [1:0] SUB_ACTIVE_CODE = 2'h0;
    localparam logic [1:0] SUB_SLEEP_CODE = 2'h1;
    localparam logic [1:0] SUB_DEEP_SLEEP_CODE = 2'h2;
    localparam logic [1:0] SUB_HIBERNATE_CODE = 2'h3;

    // result codes for the soft reset request
    localparam logic [1:0] RESULT_OK = 2'h0;
    localparam logic [1:0] INVALID_OPERATION_ERROR = 2'h1;

    // timing
    localparam int CLK_NS = 50;
    localparam int OSC_START_NS = 1000;
    localparam int OSC_START_CYC = (OSC_START_NS + CLK_NS - 1) / CLK_NS;
    localparam int OSC_SETTLE_NS = 1000;
    localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int INTERVAL_W = 16;
    localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 16'h0064;
endpackage
